/* common/idpage_pkg.sv */
// Purpose: Shared constants and types for the identify parameter page.
// Assumes: 16-bit page words, 256 words in one sector.
// Notes:   Strings are packed with the first character in the top byte.

package idpage_pkg;

  // ==========================================================================
  // Page geometry
  localparam int PAGE_WORDS = 256;          // Words in one sector
  localparam int IDX_W = 8;                 // Width of a word index
  localparam logic [7:0] LAST_IDX = 8'hff;  // Index of the final word

  // ==========================================================================
  // Word indices
  localparam logic [7:0] W_SIG = 8'h00;       // Card-type signature
  localparam logic [7:0] W_DEF_CYL = 8'h01;   // Default cylinders
  localparam logic [7:0] W_DEF_HEAD = 8'h03;  // Default heads
  localparam logic [7:0] W_DEF_SPT = 8'h06;   // Default sectors per track
  localparam logic [7:0] W_TOT_MSW = 8'h07;   // Sectors per card, high half
  localparam logic [7:0] W_TOT_LSW = 8'h08;   // Sectors per card, low half
  localparam logic [7:0] W_SERIAL = 8'h0a;    // Serial string, first word
  localparam logic [7:0] W_SERIAL_END = 8'h13;
  localparam logic [7:0] W_ECC = 8'h16;       // ECC bytes on long commands
  localparam logic [7:0] W_FW = 8'h17;        // Firmware string, first word
  localparam logic [7:0] W_FW_END = 8'h1a;
  localparam logic [7:0] W_MODEL = 8'h1b;     // Model string, first word
  localparam logic [7:0] W_MODEL_END = 8'h2e;
  localparam logic [7:0] W_MAX_MULT = 8'h2f;  // Max sectors per block
  localparam logic [7:0] W_CAPS = 8'h31;      // Capabilities
  localparam logic [7:0] W_PIO = 8'h33;       // PIO timing mode
  localparam logic [7:0] W_VALID = 8'h35;     // Field validity
  localparam logic [7:0] W_CUR_CYL = 8'h36;   // Current cylinders
  localparam logic [7:0] W_CUR_HEAD = 8'h37;  // Current heads
  localparam logic [7:0] W_CUR_SPT = 8'h38;   // Current sectors per track
  localparam logic [7:0] W_CAP_LSW = 8'h39;   // Current capacity, low half
  localparam logic [7:0] W_CAP_MSW = 8'h3a;   // Current capacity, high half
  localparam logic [7:0] W_MULT_SET = 8'h3b;  // Multiple sector setting
  localparam logic [7:0] W_LBA_LSW = 8'h3c;   // LBA sectors, low half
  localparam logic [7:0] W_LBA_MSW = 8'h3d;   // LBA sectors, high half
  localparam logic [7:0] W_MDMA = 8'h3f;      // Multiword DMA select/support
  localparam logic [7:0] W_ADV_PIO = 8'h40;   // Advanced PIO modes
  localparam logic [7:0] W_DMA_MIN = 8'h41;   // Min multiword DMA cycle
  localparam logic [7:0] W_DMA_REC = 8'h42;   // Recommended DMA cycle
  localparam logic [7:0] W_PIO_MIN = 8'h43;   // Min PIO cycle, no flow ctl
  localparam logic [7:0] W_PIO_RDY = 8'h44;   // Min PIO cycle, ready flow
  localparam logic [7:0] W_SECURITY = 8'h80;  // Security status
  localparam logic [7:0] W_RSV_LO = 8'h45;    // First zero word after 68

  // ==========================================================================
  // Fixed contents
  localparam int SERIAL_CHARS = 20;           // Serial field, characters
  localparam int FW_CHARS = 8;                // Firmware field, characters
  localparam int MODEL_CHARS = 40;            // Model field, characters
  localparam logic [15:0] ECC_COUNT = 16'h0004;  // ECC bytes per sector
  localparam logic [7:0] SPACE_CHAR = 8'h20;  // Pad character
  localparam logic [7:0] MULT_TOP = 8'h80;    // Upper byte of max multiple
  localparam logic [6:0] MULT_RSV = 7'h00;    // Reserved bits 15-9, word 59
  localparam logic MULT_VALID = 1'b1;         // Bit 8 of word 59
  localparam logic GEOM_VALID = 1'b1;         // Bit 0 of word 53
  localparam logic [7:0] ZERO_BYTE = 8'h00;   // Zero half word
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // ==========================================================================
  // Sender states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,   // Waiting for an identify request
    ST_SEND = 2'b01    // Offering page words
  } send_state_type;

  // Page contents supplied by the card's own logic
  typedef struct packed {
    logic [15:0] def_cyl;     // Default cylinders
    logic [7:0] def_heads;    // Default heads
    logic [15:0] def_spt;     // Default sectors per track
    logic [31:0] total_sec;   // Sectors per card
    logic [7:0] max_mult;     // Max sectors per multiple block
    logic [7:0] caps_hi;      // Capabilities upper byte
    logic [7:0] pio_mode;     // PIO timing mode
    logic ext_valid;          // Words 64-70 valid
    logic [15:0] cur_cyl;     // Current cylinders
    logic [15:0] cur_heads;   // Current heads
    logic [15:0] cur_spt;     // Current sectors per track
    logic [31:0] cur_cap;     // Current capacity
    logic [7:0] mult_set;     // Current sectors per interrupt
    logic [31:0] lba_sec;     // LBA addressable sectors
    logic [7:0] mdma_sel;     // Selected multiword DMA mode
    logic [7:0] mdma_sup;     // Supported multiword DMA modes
    logic [7:0] adv_pio;      // Supported advanced PIO modes
    logic [15:0] dma_min_ns;  // Min multiword DMA cycle
    logic [15:0] dma_rec_ns;  // Recommended multiword DMA cycle
    logic [15:0] pio_min_ns;  // Min PIO cycle without flow control
    logic [15:0] pio_rdy_ns;  // Min PIO cycle with ready flow control
    logic [15:0] security;    // Security status
    logic pcmcia_mode;        // Card runs in PCMCIA mode
  } page_cfg_type;

endpackage : idpage_pkg

/* src/string_word_pick.sv */
// Purpose: Picks one 16-bit word of a justified, space-padded ASCII field.
// Assumes: First character at the top byte of str; len counts characters.
// Notes:   First character of each pair lands in the upper byte.

`timescale 1ns/100ps

module string_word_pick #(
  parameter int CHARS = 20,      // Field width in characters
  parameter bit RIGHT = 1'b0     // Right justify when set
) (
  input wire logic [CHARS*8-1:0] str,
  input wire logic [7:0] len,
  input wire logic [7:0] woff,
  output logic [15:0] word
);
  import idpage_pkg::*;

  // ==========================================================================
  // Character lookup
  // Returns the character at field position pos, or a space
  function automatic logic [7:0] char_at(input int pos, input int n);
    int src;
    int lead;
    lead = RIGHT ? CHARS - n : 0;
    src = pos - lead;
    if (pos >= CHARS || src < 0 || src >= n) begin
      char_at = SPACE_CHAR;
    end else begin
      char_at = str[(CHARS-1-src)*8 +: 8];
    end
  endfunction : char_at

  // Clamp the length to the field
  int n_chars;
  always_comb begin
    n_chars = (int'(len) > CHARS) ? CHARS : int'(len);
  end

  // Upper byte holds the earlier character of the pair
  always_comb begin
    word = {char_at(2 * int'(woff), n_chars),
            char_at(2 * int'(woff) + 1, n_chars)};
  end

endmodule : string_word_pick

/* src/identify_page.sv */
// Purpose: Streams the 256-word identify parameter page as one sector.
// Assumes: cfg and strings stay stable while a page is being sent.
// Notes:   A word is taken on each edge where page_valid and page_ready.

`timescale 1ns/100ps

module identify_page #(
  parameter logic [15:0] SIGNATURE = 16'h5a3c  // Value is arbitrary
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire idpage_pkg::page_cfg_type cfg,
  input wire logic [idpage_pkg::SERIAL_CHARS*8-1:0] serial_str,
  input wire logic [7:0] serial_len,
  input wire logic [idpage_pkg::FW_CHARS*8-1:0] fw_str,
  input wire logic [idpage_pkg::MODEL_CHARS*8-1:0] model_str,
  input wire logic [7:0] model_len,
  input wire logic page_ready,
  output logic [15:0] page_data_q,
  output logic page_valid_q,
  output logic page_last_q
);
  import idpage_pkg::*;

  // ==========================================================================
  // State and index
  send_state_type state_q;     // Sender state
  send_state_type state_d;     // Next sender state
  logic [7:0] idx_q;           // Index of the word on offer
  logic [7:0] idx_d;           // Index of the next word to offer
  logic load;                  // Load a new word into the output
  logic beat;                  // Host takes the offered word
  logic [15:0] word_d;         // Content of word idx_d
  logic [15:0] serial_word;    // Serial field word
  logic [15:0] fw_word;        // Firmware field word
  logic [15:0] model_word;     // Model field word

  assign beat = page_valid_q && page_ready;

  // Advance on each taken word; the page ends after the final one
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    load = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        // A request starts a fresh page at word 0
        if (start) begin
          state_d = ST_SEND;
          idx_d = W_SIG;
          load = 1'b1;
        end
      end
      ST_SEND: begin
        // Stop after the 256th word has been taken
        if (beat && idx_q == LAST_IDX) begin
          state_d = ST_IDLE;
        end else if (beat) begin
          idx_d = idx_q + 8'h01;
          load = 1'b1;
        end
      end
      // Unused codes fall back to idle
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Field pickers
  // Serial field, right justified
  string_word_pick #(.CHARS(SERIAL_CHARS), .RIGHT(1'b1)) u_serial (
    .str(serial_str),
    .len(serial_len),
    .woff(idx_d - W_SERIAL),
    .word(serial_word)
  );

  // Firmware field, fully occupied
  string_word_pick #(.CHARS(FW_CHARS), .RIGHT(1'b0)) u_fw (
    .str(fw_str),
    .len(8'(FW_CHARS)),
    .woff(idx_d - W_FW),
    .word(fw_word)
  );

  // Model field, left justified
  string_word_pick #(.CHARS(MODEL_CHARS), .RIGHT(1'b0)) u_model (
    .str(model_str),
    .len(model_len),
    .woff(idx_d - W_MODEL),
    .word(model_word)
  );

  // ==========================================================================
  // Page content
  // Builds the word that idx_d selects
  always_comb begin
    word_d = ZERO_WORD;
    if (idx_d >= W_SERIAL && idx_d <= W_SERIAL_END) begin
      word_d = serial_word;
    end else if (idx_d >= W_FW && idx_d <= W_FW_END) begin
      word_d = fw_word;
    end else if (idx_d >= W_MODEL && idx_d <= W_MODEL_END) begin
      word_d = model_word;
    end else begin
      case (idx_d)
        W_SIG: word_d = SIGNATURE;
        W_DEF_CYL: word_d = cfg.def_cyl;
        W_DEF_HEAD: word_d = {ZERO_BYTE, cfg.def_heads};
        W_DEF_SPT: word_d = cfg.def_spt;
        W_TOT_MSW: word_d = cfg.total_sec[31:16];
        W_TOT_LSW: word_d = cfg.total_sec[15:0];
        W_ECC: word_d = ECC_COUNT;
        W_MAX_MULT: word_d = {MULT_TOP, cfg.max_mult};
        W_CAPS: word_d = {cfg.caps_hi, ZERO_BYTE};
        W_PIO: word_d = {cfg.pio_mode, ZERO_BYTE};
        W_VALID: word_d = {14'h0000, cfg.ext_valid, GEOM_VALID};
        W_CUR_CYL: word_d = cfg.cur_cyl;
        W_CUR_HEAD: word_d = cfg.cur_heads;
        W_CUR_SPT: word_d = cfg.cur_spt;
        W_CAP_LSW: word_d = cfg.cur_cap[15:0];
        W_CAP_MSW: word_d = cfg.cur_cap[31:16];
        W_MULT_SET: word_d = {MULT_RSV, MULT_VALID, cfg.mult_set};
        W_LBA_LSW: word_d = cfg.lba_sec[15:0];
        W_LBA_MSW: word_d = cfg.lba_sec[31:16];
        W_MDMA: begin
          // DMA select and support vanish in PCMCIA mode
          word_d = cfg.pcmcia_mode ? ZERO_WORD
                                   : {cfg.mdma_sel, cfg.mdma_sup};
        end
        W_ADV_PIO: word_d = {ZERO_BYTE, cfg.adv_pio};
        W_DMA_MIN: begin
          word_d = cfg.pcmcia_mode ? ZERO_WORD : cfg.dma_min_ns;
        end
        W_DMA_REC: begin
          word_d = cfg.pcmcia_mode ? ZERO_WORD : cfg.dma_rec_ns;
        end
        W_PIO_MIN: word_d = cfg.pio_min_ns;
        W_PIO_RDY: word_d = cfg.pio_rdy_ns;
        W_SECURITY: word_d = cfg.security;
        default: word_d = ZERO_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // Sender state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Word index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 8'h00;
    end else begin
      idx_q <= idx_d;
    end
  end

  // Output word, held until the host takes it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_data_q <= 16'h0000;
    end else if (load) begin
      page_data_q <= word_d;
    end
  end

  // Valid and last flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_valid_q <= 1'b0;
      page_last_q <= 1'b0;
    end else begin
      page_valid_q <= (state_d == ST_SEND);
      page_last_q <= (state_d == ST_SEND) && (idx_d == LAST_IDX);
    end
  end

  // ==========================================================================
  // Checks
  // Offered word with a given index
  sequence s_offer(logic [7:0] i);
    page_valid_q && idx_q == i;
  endsequence

  // Final word taken by the host
  sequence s_final_beat;
    page_valid_q && page_ready && idx_q == LAST_IDX;
  endsequence

  property p_sig;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_IDLE && start) |=>
        page_valid_q && idx_q == W_SIG && page_data_q == SIGNATURE;
  endproperty
  a_sig: assert property (p_sig) else $error("word 0 not signature");

  property p_total;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_TOT_MSW) ##0 page_ready |=>
        page_data_q == cfg.total_sec[15:0] &&
        $past(page_data_q) == cfg.total_sec[31:16];
  endproperty
  a_total: assert property (p_total) else $error("sector count order");

  property p_ecc;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_ECC) |-> page_data_q == ECC_COUNT;
  endproperty
  a_ecc: assert property (p_ecc) else $error("ecc count wrong");

  property p_pio;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_PIO) |-> page_data_q == {cfg.pio_mode, ZERO_BYTE};
  endproperty
  a_pio: assert property (p_pio) else $error("pio mode word wrong");

  property p_mdma;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_MDMA) ##0 cfg.pcmcia_mode |-> page_data_q == ZERO_WORD;
  endproperty
  a_mdma: assert property (p_mdma) else $error("dma word not zero");

  property p_adv;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_ADV_PIO) |-> page_data_q[15:8] == ZERO_BYTE &&
                             page_data_q[7:0] == cfg.adv_pio;
  endproperty
  a_adv: assert property (p_adv) else $error("adv pio word wrong");

  property p_rsv;
    @(posedge core_clk) disable iff (!rst_n)
      page_valid_q && idx_q >= W_RSV_LO && idx_q != W_SECURITY |->
        page_data_q == ZERO_WORD;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved word not zero");

  property p_mult;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_MULT_SET) |-> page_data_q[15:8] == 8'h01 &&
                              page_data_q[7:0] == cfg.mult_set;
  endproperty
  a_mult: assert property (p_mult) else $error("multiple setting wrong");

  property p_geom;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_VALID) |-> page_data_q[0];
  endproperty
  a_geom: assert property (p_geom) else $error("geometry valid unset");

  property p_end;
    @(posedge core_clk) disable iff (!rst_n)
      s_final_beat |-> page_last_q ##1 (!page_valid_q && !page_last_q);
  endproperty
  a_end: assert property (p_end) else $error("page did not end");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      page_valid_q && !page_ready |=>
        page_valid_q && $stable(page_data_q) && $stable(idx_q);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped on stall");

  property p_model_pad;
    @(posedge core_clk) disable iff (!rst_n)
      s_offer(W_MODEL_END) ##0 model_len <= 8'h26 |->
        page_data_q == {SPACE_CHAR, SPACE_CHAR};
  endproperty
  a_model_pad: assert property (p_model_pad) else $error("no pad");

endmodule : identify_page

/* test/page_host_model.sv */
// Purpose: Host side reader that takes the identify page word by word.
// Assumes: Word stream handshake, one word per edge with valid and ready.
// Notes:   Slow mode drops ready every other cycle to stall the sender.

`timescale 1ns/100ps

module page_host_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic clear,
  input wire logic [15:0] page_data_q,
  input wire logic page_valid_q,
  input wire logic page_last_q,
  output logic page_ready,
  output int taken
);
  // ==========================================================================
  // Captured sector
  logic [15:0] words [256];  // Words in arrival order
  logic lasts [256];         // Last flag seen with each word

  // Ready changes off the sampling edge; slow mode toggles it
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_ready <= 1'b0;
    end else begin
      page_ready <= slow ? ~page_ready : 1'b1;
    end
  end

  // Take one word per handshake edge, as one sector read
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 0;
    end else if (clear) begin
      taken <= 0;
    end else if (page_valid_q && page_ready) begin
      words[taken[7:0]] <= page_data_q;
      lasts[taken[7:0]] <= page_last_q;
      taken <= taken + 1;
    end
  end
endmodule : page_host_model

/* test/identify_page_tb.sv */
// Purpose: Self-checking bench for the identify parameter page sender.
// Assumes: Inputs driven at the falling edge, page contents held steady.
// Notes:   Expected words are built here from the page layout.

`timescale 1ns/100ps

module identify_page_tb;
  import idpage_pkg::*;

  // ==========================================================================
  // Signals
  localparam logic [15:0] SIG = 16'h3c5a;  // Value is arbitrary
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  page_cfg_type cfg;
  logic [159:0] serial_str = "SN0123456789ABCDEFGH";
  logic [7:0] serial_len = 8'h14;
  logic [63:0] fw_str = "REV1.2.3";
  logic [319:0] model_str = "MODEL-FLASH-CARD-IND-0123456789-ABCDEFGH";
  logic [7:0] model_len = 8'h28;
  logic page_ready, page_valid_q, page_last_q;
  logic [15:0] page_data_q;
  logic slow = 1'b0;
  logic clear = 1'b0;
  int taken;
  int miscompares = 0;
  int samples_checked = 0;

  always #2.5 core_clk = ~core_clk;

  identify_page #(.SIGNATURE(SIG)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .start(start), .cfg(cfg),
    .serial_str(serial_str), .serial_len(serial_len), .fw_str(fw_str),
    .model_str(model_str), .model_len(model_len), .page_ready(page_ready),
    .page_data_q(page_data_q), .page_valid_q(page_valid_q),
    .page_last_q(page_last_q));

  page_host_model host (
    .core_clk(core_clk), .rst_n(rst_n), .slow(slow), .clear(clear),
    .page_data_q(page_data_q), .page_valid_q(page_valid_q),
    .page_last_q(page_last_q), .page_ready(page_ready), .taken(taken));

  // ==========================================================================
  // Checking helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Serial character at a field position, right justified with spaces
  function automatic logic [7:0] schr(input int p);
    int n, pad;
    n = (serial_len > 20) ? 20 : int'(serial_len);
    pad = 20 - n;
    return (p < pad) ? 8'h20 : serial_str[159-8*(p-pad) -: 8];
  endfunction : schr

  // Model character at a field position, left justified with spaces
  function automatic logic [7:0] mchr(input int p);
    int n;
    n = (model_len > 40) ? 40 : int'(model_len);
    return (p < n) ? model_str[319-8*p -: 8] : 8'h20;
  endfunction : mchr

  // Expected content of one page word
  function automatic logic [15:0] exp_word(input int i);
    logic [15:0] w;
    logic pcm;
    pcm = cfg.pcmcia_mode;
    w = 16'h0000;
    if (i >= 10 && i <= 19) w = {schr(2*i-20), schr(2*i-19)};
    if (i >= 23 && i <= 26) w = fw_str[63-16*(i-23) -: 16];
    if (i >= 27 && i <= 46) w = {mchr(2*i-54), mchr(2*i-53)};
    case (i)
      0: w = SIG;
      1: w = cfg.def_cyl;
      3: w = {8'h00, cfg.def_heads};
      6: w = cfg.def_spt;
      7: w = cfg.total_sec[31:16];
      8: w = cfg.total_sec[15:0];
      22: w = 16'h0004;
      47: w = {8'h80, cfg.max_mult};
      49: w = {cfg.caps_hi, 8'h00};
      51: w = {cfg.pio_mode, 8'h00};
      53: w = {14'h0000, cfg.ext_valid, 1'b1};
      54: w = cfg.cur_cyl;
      55: w = cfg.cur_heads;
      56: w = cfg.cur_spt;
      57: w = cfg.cur_cap[15:0];
      58: w = cfg.cur_cap[31:16];
      59: w = {7'h00, 1'b1, cfg.mult_set};
      60: w = cfg.lba_sec[15:0];
      61: w = cfg.lba_sec[31:16];
      63: w = pcm ? 16'h0000 : {cfg.mdma_sel, cfg.mdma_sup};
      64: w = {8'h00, cfg.adv_pio};
      65: w = pcm ? 16'h0000 : cfg.dma_min_ns;
      66: w = pcm ? 16'h0000 : cfg.dma_rec_ns;
      67: w = cfg.pio_min_ns;
      68: w = cfg.pio_rdy_ns;
      128: w = cfg.security;
      default: ;
    endcase
    return w;
  endfunction : exp_word

  // Request one page and compare every word taken by the host
  task automatic run_page;
    int n;
    @(negedge core_clk) clear = 1'b1;
    @(negedge core_clk) clear = 1'b0;
    start = 1'b1;
    n = 0;
    while (taken < 256 && n < 2000) begin
      @(negedge core_clk);
      start = (taken == 100);  // Ignored while sending
      n++;
    end
    start = 1'b0;
    repeat (3) @(negedge core_clk);
    check(16'(taken), 16'd256);
    check({15'h0000, page_valid_q}, 16'h0000);
    for (int i = 0; i < 256; i++) begin
      check(host.words[i], exp_word(i));
      check({15'h0000, host.lasts[i]}, {15'h0000, i == 255});
    end
  endtask : run_page

  // ==========================================================================
  // Scenarios
  task automatic scenario_full_fast;
    slow = 1'b0;
    run_page();
  endtask : scenario_full_fast

  task automatic scenario_reset_mid_page;
    @(negedge core_clk) start = 1'b1;
    @(negedge core_clk) start = 1'b0;
    repeat (30) @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    check(page_data_q, 16'h0000);
    check({14'h0000, page_valid_q, page_last_q}, 16'h0000);
    rst_n = 1'b1;
    run_page();
  endtask : scenario_reset_mid_page

  task automatic scenario_short_slow_pcmcia;
    slow = 1'b1;
    serial_len = 8'h05;
    model_len = 8'h07;
    cfg.pcmcia_mode = 1'b1;
    cfg.ext_valid = 1'b0;
    cfg.total_sec = 32'h8001_fffe;
    run_page();
  endtask : scenario_short_slow_pcmcia

  task automatic scenario_clamped_lengths;
    slow = 1'b0;
    serial_len = 8'h00;
    model_len = 8'h2d;
    cfg.pcmcia_mode = 1'b0;
    run_page();
  endtask : scenario_clamped_lengths

  // ==========================================================================
  // Main sequence
  initial begin
    cfg = '0;
    cfg.def_cyl = 16'h03d1;
    cfg.def_heads = 8'h10;
    cfg.def_spt = 16'h003f;
    cfg.total_sec = 32'h00ef_5670;
    cfg.max_mult = 8'h01;
    cfg.caps_hi = 8'h0b;
    cfg.pio_mode = 8'h02;
    cfg.ext_valid = 1'b1;
    cfg.cur_cyl = 16'h03d2;
    cfg.cur_heads = 16'h000f;
    cfg.cur_spt = 16'h003e;
    cfg.cur_cap = 32'h00ee_1234;
    cfg.mult_set = 8'h01;
    cfg.lba_sec = 32'h00ef_5671;
    cfg.mdma_sel = 8'h04;
    cfg.mdma_sup = 8'h07;
    cfg.adv_pio = 8'h03;
    cfg.dma_min_ns = 16'h0078;
    cfg.dma_rec_ns = 16'h0079;
    cfg.pio_min_ns = 16'h00f0;
    cfg.pio_rdy_ns = 16'h0077;
    cfg.security = 16'h0021;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    scenario_full_fast();
    scenario_reset_mid_page();
    scenario_short_slow_pcmcia();
    scenario_clamped_lengths();
    conclude();
  end

  // Watchdog sized well above four pages with stalls
  initial begin
    #50000;
    miscompares++;
    conclude();
  end
endmodule : identify_page_tb
